// ==== verilog/charger_thermal_input_foldback.sv ====
/*
  thermal foldback and input-voltage regulation control for the charger
  current target. the comparator bank is external; register access is a
  plain write/read port at the documented address.
  assumes comparators report the first/second/third set point crossings
  relative to the chosen selector (sp0 is the programmed set point).
*/
//
// Operation
// - first set point halves the target
// - back to full below first minus 5
// - second set point quarters the target
// - back to half below second minus 5
// - third set point gives one eighth
// - back to quarter below third minus 5
// - 125 c forces fixed 100 ma
// - leave 100 ma only below 120 c
// - foldback disabled in low power state
// - folded-back target never below 100 ma
// - foldback never raises a fault
// - selector codes 80, 95, 110 c
// - regulation threshold lowers input limit
// - debounced regulation event raises interrupt
// - deep sag forces 100 ma at once
// - step up every 10 ms if input good
// - thermal change interrupt and sense bit
`timescale 1ns/100ps
`default_nettype none
module charger_thermal_input_foldback
  import foldback_pkg::*;
#(
  parameter int STEP_CNT = STEP_CYCLES,        // 10 ms step-up interval in cycles
  parameter int DEB_CNT  = DEBOUNCE_CYCLES     // regulation debounce in cycles
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    reg_wr_in,       // register write strobe
  input  wire logic [7:0]              reg_addr_in,     // register address
  input  wire logic [7:0]              reg_wdata_in,    // write data
  output logic      [7:0]              reg_rdata_out,   // read data
  input  wire foldback_pkg::comp_type  comp_in,         // raw comparator levels
  input  wire logic                    low_power_state_in,
  input  wire logic [10:0]             cc_target_in,    // final cc value in ma
  input  wire logic [10:0]             input_limit_in,  // programmed input limit, ma
  output logic [10:0]                  charge_target_out,
  output logic [10:0]                  input_limit_eff_out,
  output logic                         thermal_loop_sense_out,
  output logic                         thermal_change_irq_out,
  output logic                         dynamic_input_power_loop_irq_out,
  output logic                         fault_out
);
  import foldback_pkg::*;

  // ===========================================================
  // register
  // ===========================================================
  logic [7:0] ctrl_reg;                        // thermal_regulation_control

  // software writes; reserved bit held at zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= THERMAL_CTRL_RESET;
    end else if (reg_wr_in && reg_addr_in == THERMAL_CTRL_ADDR) begin
      ctrl_reg <= reg_wdata_in & THERMAL_CTRL_WMASK;
    end
  end

  // read mux, unmapped reads zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= (reg_addr_in == THERMAL_CTRL_ADDR) ? ctrl_reg : 8'h00;
    end
  end

  logic       fb_enable;                       // foldback_enable
  logic [1:0] setpoint_sel;                    // foldback_setpoint_sel
  logic [2:0] sp_ok;                           // which set points exist
  assign fb_enable    = ctrl_reg[FB_EN_BIT];
  assign setpoint_sel = ctrl_reg[SETPOINT_LSB +: 2];
  assign sp_ok        = sp_valid(setpoint_sel);

  // ===========================================================
  // comparator synchronisers
  // ===========================================================
  comp_type sync1_reg;                         // first stage, read only by second
  comp_type sync2_reg;                         // safe copy for the state machines

  // two flops keep metastability out of the fsm decisions
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= comp_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ===========================================================
  // thermal foldback level
  // ===========================================================
  fold_level_type level_reg;
  fold_level_type level_next;
  logic           fb_active;

  // disabled or low power forces full current
  assign fb_active = fb_enable && !low_power_state_in;

  // one step per clock; hot side checked first
  always_comb begin
    level_next = level_reg;
    case (level_reg)
      LVL_FULL: begin
        if (sync2_reg.ge_125)                         level_next = LVL_FLOOR;
        else if (sync2_reg.ge_sp0 && sp_ok[0])        level_next = LVL_HALF;
      end
      LVL_HALF: begin
        if (sync2_reg.ge_125)                         level_next = LVL_FLOOR;
        else if (sync2_reg.ge_sp1 && sp_ok[1])        level_next = LVL_QUARTER;
        else if (sync2_reg.lt_sp0h)                   level_next = LVL_FULL;
      end
      LVL_QUARTER: begin
        if (sync2_reg.ge_125)                         level_next = LVL_FLOOR;
        else if (sync2_reg.ge_sp2 && sp_ok[2])        level_next = LVL_EIGHTH;
        else if (sync2_reg.lt_sp1h)                   level_next = LVL_HALF;
      end
      LVL_EIGHTH: begin
        if (sync2_reg.ge_125)                         level_next = LVL_FLOOR;
        else if (sync2_reg.lt_sp2h)                   level_next = LVL_QUARTER;
      end
      LVL_FLOOR: begin
        // return to eighth; lower steps unwind from there
        if (sync2_reg.lt_120)                         level_next = LVL_EIGHTH;
      end
      default:                                        level_next = LVL_FULL;
    endcase
    if (!fb_active) level_next = LVL_FULL;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_reg <= LVL_FULL;
    end else begin
      level_reg <= level_next;
    end
  end

  // target from level, floored at 100 ma except at full level
  function automatic logic [10:0] fold_target(input fold_level_type lvl,
                                              input logic [10:0] cc);
    logic [10:0] t;
    t = cc;
    case (lvl)
      LVL_FULL:    t = cc;
      LVL_HALF:    t = cc >> 1;
      LVL_QUARTER: t = cc >> 2;
      LVL_EIGHTH:  t = cc >> 3;
      LVL_FLOOR:   t = FLOOR_MA;
      default:     t = cc;
    endcase
    if (lvl != LVL_FULL && t < FLOOR_MA) t = FLOOR_MA;
    fold_target = t;
  endfunction

  // ===========================================================
  // input-voltage regulation loop
  // ===========================================================
  logic [10:0] vin_limit_reg;                  // reduced input limit
  logic [31:0] step_cnt_reg;                   // 10 ms step timer
  logic        step_tick;

  assign step_tick = (step_cnt_reg == 32'(STEP_CNT - 1));

  // free-running step timer; restarted by a deep sag
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_cnt_reg <= 32'h0;
    end else if (sync2_reg.vin_deep || step_tick) begin
      step_cnt_reg <= 32'h0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h1;
    end
  end

  // deep sag drops hard; regulation steps down; good input steps up
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vin_limit_reg <= 11'h7ff;
    end else if (sync2_reg.vin_deep) begin
      vin_limit_reg <= FLOOR_MA;
    end else if (step_tick && sync2_reg.vin_reg && vin_limit_reg > FLOOR_MA) begin
      // never step below the floor, a partial step lands on it
      vin_limit_reg <= (vin_limit_reg - FLOOR_MA > STEP_MA) ?
                       vin_limit_reg - STEP_MA : FLOOR_MA;
    end else if (step_tick && !sync2_reg.vin_reg && vin_limit_reg < input_limit_in) begin
      // last step lands on the programmed limit; a full step could wrap 11 bits
      vin_limit_reg <= (input_limit_in - vin_limit_reg > STEP_MA) ?
                       vin_limit_reg + STEP_MA : input_limit_in;
    end else if (vin_limit_reg > input_limit_in) begin
      vin_limit_reg <= input_limit_in;
    end
  end

  // debounce of the regulation event
  logic [15:0] deb_cnt_reg;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      deb_cnt_reg <= 16'h0;
    end else if (!sync2_reg.vin_reg) begin
      deb_cnt_reg <= 16'h0;
    end else if (deb_cnt_reg != 16'(DEB_CNT)) begin
      deb_cnt_reg <= deb_cnt_reg + 16'h1;
    end
  end

  // ===========================================================
  // outputs
  // ===========================================================
  logic [10:0] fold_t;
  logic [10:0] vin_t;
  assign fold_t = fold_target(level_reg, cc_target_in);
  assign vin_t  = (vin_limit_reg < cc_target_in) ? vin_limit_reg : cc_target_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      charge_target_out                <= 11'h0;
      input_limit_eff_out              <= 11'h0;
      thermal_loop_sense_out           <= 1'b0;
      thermal_change_irq_out           <= 1'b0;
      dynamic_input_power_loop_irq_out <= 1'b0;
      fault_out                        <= 1'b0;
    end else begin
      charge_target_out      <= (vin_t < fold_t) ? vin_t : fold_t;
      input_limit_eff_out    <= vin_limit_reg;
      thermal_loop_sense_out <= (level_reg != LVL_FULL);
      thermal_change_irq_out <= (level_next != level_reg);
      dynamic_input_power_loop_irq_out <= (deb_cnt_reg == 16'(DEB_CNT - 1));
      fault_out              <= 1'b0;
    end
  end

  // ===========================================================
  // checks
  // ===========================================================
  // step windows of the input loop, shared by the two step checks
  sequence s_step_down_window;
    step_tick && sync2_reg.vin_reg && !sync2_reg.vin_deep && vin_limit_reg > FLOOR_MA;
  endsequence
  sequence s_step_up_window;
    step_tick && !sync2_reg.vin_reg && !sync2_reg.vin_deep
    && vin_limit_reg < input_limit_in;
  endsequence

  // hot entries into the next level, the 125 c limit not yet reached
  sequence s_quarter_trip;
    level_reg == LVL_HALF && fb_active && sp_ok[1] && sync2_reg.ge_sp1
    && !sync2_reg.ge_125;
  endsequence
  sequence s_eighth_trip;
    level_reg == LVL_QUARTER && fb_active && sp_ok[2] && sync2_reg.ge_sp2
    && !sync2_reg.ge_125;
  endsequence

  a_floor_at_125: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (fb_active && sync2_reg.ge_125 && $past(fb_active)) |=> level_reg == LVL_FLOOR)
    else $error("125 c did not force floor level");
  a_lpm_full: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !fb_active |=> level_reg == LVL_FULL)
    else $error("foldback active in low power");
  a_deep_sag_floor: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sync2_reg.vin_deep |=> vin_limit_reg == FLOOR_MA)
    else $error("deep sag did not force 100 ma");
  a_no_fault_out: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !fault_out)
    else $error("fault raised by foldback");
  a_irq_on_change: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(level_reg) |-> thermal_change_irq_out)
    else $error("thermal change without interrupt");
  a_target_lowest: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ##1 charge_target_out <= $past(fold_t))
    else $error("target above foldback level");
  a_half_entry: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (level_reg == LVL_FULL && fb_active && sp_ok[0] && sync2_reg.ge_sp0
     && !sync2_reg.ge_125) |=> level_reg == LVL_HALF)
    else $error("first set point did not halve");
  a_floor_exit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (level_reg == LVL_FLOOR && fb_active && !sync2_reg.lt_120) |=> level_reg == LVL_FLOOR)
    else $error("left floor above 120 c");
  a_quarter_entry: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_quarter_trip |=> level_reg == LVL_QUARTER)
    else $error("second set point did not quarter");
  a_eighth_entry: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_eighth_trip |=> level_reg == LVL_EIGHTH)
    else $error("third set point did not give one eighth");
  a_half_exit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (level_reg == LVL_HALF && fb_active && sync2_reg.lt_sp0h && !sync2_reg.ge_125
     && !(sp_ok[1] && sync2_reg.ge_sp1)) |=> level_reg == LVL_FULL)
    else $error("half level kept below hysteresis point");
  a_step_down: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_step_down_window |=> vin_limit_reg < $past(vin_limit_reg) && vin_limit_reg >= FLOOR_MA)
    else $error("regulation did not step the input limit down");
  a_step_up: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_step_up_window |=> vin_limit_reg > $past(vin_limit_reg))
    else $error("good input did not step the input limit up");
  a_dpm_irq_cause: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    dynamic_input_power_loop_irq_out |-> $past(sync2_reg.vin_reg, 2))
    else $error("regulation interrupt without a regulation event");
  a_fold_floor: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (level_reg != LVL_FULL) |-> fold_t >= FLOOR_MA)
    else $error("foldback target below 100 ma");

endmodule
`default_nettype wire

// ==== verilog/foldback_pkg.sv ====
/*
  constants, encodings and carrier structs for the charger thermal foldback
  and input-voltage step-up control.
  assumes a 250 mhz internal clock and comparator levels from the analog side.
*/
`default_nettype none
package foldback_pkg;

  // ===========================================================
  // register map
  // ===========================================================
  localparam logic [7:0] THERMAL_CTRL_ADDR  = 8'h92;  // thermal_regulation_control
  localparam logic [7:0] THERMAL_CTRL_RESET = 8'h05;  // reset value
  localparam logic [7:0] THERMAL_CTRL_WMASK = 8'hbf;  // bit 6 reserved, reads zero
  localparam int         FB_EN_BIT          = 7;      // foldback_enable
  localparam int         HOT_BIT            = 5;      // hot_threshold_sel
  localparam int         COLD_BIT           = 4;      // cold_threshold_sel
  localparam int         SETPOINT_LSB       = 2;      // foldback_setpoint_sel [3:2]
  localparam int         THM_CFG_LSB        = 0;      // thermistor_config [1:0]

  // ===========================================================
  // set point selector codes
  // ===========================================================
  localparam logic [1:0] SETPOINT_80C  = 2'h0;
  localparam logic [1:0] SETPOINT_95C  = 2'h1;
  localparam logic [1:0] SETPOINT_110C = 2'h2;
  localparam logic [1:0] SETPOINT_RSVD = 2'h3;

  // ===========================================================
  // current targets, in ma
  // ===========================================================
  localparam int         CUR_W         = 11;
  localparam logic [10:0] FLOOR_MA     = 11'h064;     // 100 ma floor
  localparam logic [10:0] STEP_MA      = 11'h032;     // 50 ma step-up increment

  // ===========================================================
  // timing
  // ===========================================================
  localparam int CLK_MHZ       = 250;
  localparam int STEP_MS       = 10;                  // step-up interval
  localparam int STEP_CYCLES   = STEP_MS * 1000 * CLK_MHZ;
  localparam int DEBOUNCE_US   = 10;                  // regulation event debounce
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

  // ===========================================================
  // foldback levels, one-hot
  // ===========================================================
  typedef enum logic [4:0] {
    LVL_FULL    = 5'h01,
    LVL_HALF    = 5'h02,
    LVL_QUARTER = 5'h04,
    LVL_EIGHTH  = 5'h08,
    LVL_FLOOR   = 5'h10
  } fold_level_type;

  // comparator bundle from the analog side
  typedef struct packed {
    logic ge_sp0;   // temp reached first set point
    logic ge_sp1;   // reached second set point
    logic ge_sp2;   // reached third set point
    logic ge_125;   // reached 125 c
    logic lt_sp0h;  // below first set point minus 5 c
    logic lt_sp1h;  // below second minus 5 c
    logic lt_sp2h;  // below third minus 5 c
    logic lt_120;   // below 120 c
    logic vin_reg;  // input at or below regulation threshold
    logic vin_deep; // input 200 mv below threshold
  } comp_type;

  // thermal bits with active levels only for valid set points
  function automatic logic [2:0] sp_valid(input logic [1:0] sel);
    case (sel)
      SETPOINT_80C:  sp_valid = 3'h7;
      SETPOINT_95C:  sp_valid = 3'h3;
      SETPOINT_110C: sp_valid = 3'h1;
      default:       sp_valid = 3'h0;
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== verification/comp_bank_model.sv ====
/*
  behavioural model of the analog comparator bank seen by the foldback
  control: junction temperature and input-voltage comparator levels.
  assumes set points two and three sit 15 c and 30 c above the first.
*/
`timescale 1ns/100ps
`default_nettype none
module comp_bank_model
  import foldback_pkg::*;
(
  input  wire logic [7:0]        temp_c_in,  // junction temperature, deg c
  input  wire logic [1:0]        sel_in,     // programmed set point code
  input  wire logic              sag_in,     // input at regulation threshold
  input  wire logic              deep_in,    // input 200 mv under threshold
  output var  foldback_pkg::comp_type comp_out    // comparator levels
);
  logic [7:0] sp0;  // first set point, deg c

  // ===========================================================
  // set point decode, reserved code falls back to the top one
  // ===========================================================
  always_comb begin
    case (sel_in)
      2'h0: sp0 = 8'h50;
      2'h1: sp0 = 8'h5f;
      default: sp0 = 8'h6e;
    endcase
  end

  // levels are ideal; hysteresis is 5 c below each trip point
  always_comb begin
    comp_out.ge_sp0   = temp_c_in >= sp0;
    comp_out.ge_sp1   = temp_c_in >= sp0 + 8'h0f;
    comp_out.ge_sp2   = temp_c_in >= sp0 + 8'h1e;
    comp_out.ge_125   = temp_c_in >= 8'h7d;
    comp_out.lt_sp0h  = temp_c_in < sp0 - 8'h05;
    comp_out.lt_sp1h  = temp_c_in < sp0 + 8'h0a;
    comp_out.lt_sp2h  = temp_c_in < sp0 + 8'h19;
    comp_out.lt_120   = temp_c_in < 8'h78;
    comp_out.vin_reg  = sag_in;
    comp_out.vin_deep = deep_in;
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
/*
  self-checking bench for the charger foldback control.
  assumes short step and debounce counts and the comparator bank model.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import foldback_pkg::*;
  localparam int STEP = 20;  // shortened step-up interval
  logic        clk_in = 1'b0;  // 250 mhz clock
  logic        rst_b_in = 1'b0;  // active low reset
  logic        wr = 1'b0;  // write strobe
  logic [7:0]  addr = 8'h00;  // register address
  logic [7:0]  wdata = 8'h00;  // write data
  logic [7:0]  rdata;  // read data
  logic [7:0]  temp = 8'h46;  // junction temperature
  logic [1:0]  sel = 2'h0;  // selector mirrored into the model
  logic        sag = 1'b0;  // regulation comparator
  logic        deep = 1'b0;  // deep sag comparator
  logic        lp = 1'b0;  // low power state
  logic [10:0] cc = 11'h640;  // final cc value, 1600 ma
  logic [10:0] ilim = 11'h7ff;  // programmed input limit
  logic [10:0] target, ieff;  // outputs under check
  logic        sense, tirq, dirq, fault_out;  // status outputs
  comp_type    comp;  // model to design
  int          fails = 0;  // mismatch count
  int          n_tests = 0;  // comparison count

  always #2 clk_in = ~clk_in;

  comp_bank_model i_comp_bank_model (.temp_c_in(temp), .sel_in(sel), .sag_in(sag),
    .deep_in(deep), .comp_out(comp));
  charger_thermal_input_foldback #(.STEP_CNT(STEP), .DEB_CNT(5))
    i_charger_thermal_input_foldback (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .comp_in(comp), .low_power_state_in(lp), .cc_target_in(cc), .input_limit_in(ilim),
    .charge_target_out(target), .input_limit_eff_out(ieff),
    .thermal_loop_sense_out(sense), .thermal_change_irq_out(tirq),
    .dynamic_input_power_loop_irq_out(dirq), .fault_out(fault_out));

  // ===========================================================
  // bus helpers, inputs move 1 ns after the edge
  // ===========================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a; wdata = d; wr = 1'b1;
    tick(1);
    wr = 1'b0;
    sel = (a == THERMAL_CTRL_ADDR) ? d[3:2] : sel;  // keep model in step
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    tick(2);
    `CHECK(rdata, e)
  endtask
  // temperature step; counts change pulses, negative count skips that check
  task automatic set_temp(input logic [7:0] t, input logic [10:0] e, input int irqs);
    int seen;
    seen = 0;
    temp = t;
    repeat (10) begin tick(1); if (tirq === 1'b1) seen++; end
    `CHECK(target, e)
    `CHECK(sense, e !== cc)
    `CHECK(fault_out, 1'b0)
    if (irqs >= 0) `CHECK(seen, irqs)
  endtask

  // ===========================================================
  // scenarios
  // ===========================================================
  task automatic t_regs;
    reg_chk(THERMAL_CTRL_ADDR, 8'h05);
    reg_chk(8'h93, 8'h00);
    reg_wr(THERMAL_CTRL_ADDR, 8'hff);
    reg_chk(THERMAL_CTRL_ADDR, 8'hbf);
    reg_wr(8'h93, 8'h00);
    reg_chk(THERMAL_CTRL_ADDR, 8'hbf);
    reg_wr(THERMAL_CTRL_ADDR, 8'h80);
  endtask
  task automatic t_ramp;
    set_temp(8'd70, 11'h640, 0);
    set_temp(8'd80, 11'h320, 1);
    set_temp(8'd76, 11'h320, 0);
    set_temp(8'd74, 11'h640, 1);
    set_temp(8'd80, 11'h320, 1);
    set_temp(8'd95, 11'h190, 1);
    set_temp(8'd91, 11'h190, 0);
    set_temp(8'd89, 11'h320, 1);
    set_temp(8'd95, 11'h190, 1);
    set_temp(8'd110, 11'h0c8, 1);
    set_temp(8'd104, 11'h190, 1);
    set_temp(8'd110, 11'h0c8, 1);
    set_temp(8'd125, 11'h064, 1);
    set_temp(8'd121, 11'h064, 0);
    set_temp(8'd119, 11'h0c8, 1);
    set_temp(8'd70, 11'h640, -1);
  endtask
  task automatic t_floor_lp;
    cc = 11'h190;
    set_temp(8'd110, 11'h064, -1);
    set_temp(8'd125, 11'h064, -1);
    set_temp(8'd70, 11'h190, -1);
    cc = 11'h640;
    lp = 1'b1;
    set_temp(8'd100, 11'h640, 0);
    lp = 1'b0;
    set_temp(8'd70, 11'h640, -1);
  endtask
  task automatic t_codes;
    logic [7:0] sp[3];
    sp = '{8'd80, 8'd95, 8'd110};
    for (int i = 0; i < 3; i++) begin
      reg_wr(THERMAL_CTRL_ADDR, 8'h80 | (8'(i) << 2));
      reg_chk(THERMAL_CTRL_ADDR, 8'h80 | (8'(i) << 2));
      set_temp(sp[i] - 8'd1, 11'h640, 0);
      set_temp(sp[i], 11'h320, 1);
      set_temp(8'd70, 11'h640, 1);
    end
    // reserved code: no set point trips, only the 125 c level remains
    reg_wr(THERMAL_CTRL_ADDR, 8'h8c);
    reg_chk(THERMAL_CTRL_ADDR, 8'h8c);
    set_temp(8'd115, 11'h640, 0);
    set_temp(8'd125, 11'h064, 1);
    set_temp(8'd70, 11'h640, -1);
  endtask
  task automatic t_vin;
    int seen;
    seen = 0;
    sag = 1'b1;
    repeat (40) begin tick(1); if (dirq === 1'b1) seen++; end
    `CHECK(seen, 1)
    `CHECK(ieff < ilim, 1'b1)
    `CHECK(target <= ieff, 1'b1)
    deep = 1'b1;
    tick(8);
    `CHECK(target, 11'h064)
    `CHECK(ieff, FLOOR_MA)
    deep = 1'b0;
    tick(3 * STEP);
    `CHECK(target, 11'h064)
    sag = 1'b0;
    tick(2 * STEP + 8);
    `CHECK(target > 11'h064 && target <= 11'h0c8 && target % 11'd50 == 11'd0, 1'b1)
    tick(40 * STEP);
    `CHECK(target, 11'h640)
  endtask

  // ===========================================================
  // verdict and sequence
  // ===========================================================
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog, well above the roughly 1300 cycles the tests need
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
  initial begin
    tick(20);
    rst_b_in = 1'b1;
    t_regs;
    t_ramp;
    t_floor_lp;
    t_codes;
    t_vin;
    end_of_test;
  end
endmodule
`default_nettype wire
